/* rtl/lpddr2_ctl_end.sv */
// Purpose: Controller end: turns user requests into Activate, Read or
//          Write, then Precharge on the link, and moves burst data.
// Assumes: Write latency >= 1; read latency >= 2.
// Notes:   Closed-page policy, one request in flight at a time.
`timescale 1ns/1ps
module lpddr2_ctl_end #(
   parameter int DW = 32
) (
   input  wire logic                          i_clk,
   input  wire logic                          i_reset_n,
   lpddr2_link_if.ctl                         link,
   input  wire logic [lpddr2_pkg::BLC_W-1:0]  i_bl_code,
   input  wire logic [lpddr2_pkg::LAT_W-1:0]  i_read_lat,
   input  wire logic [lpddr2_pkg::LAT_W-1:0]  i_write_lat,
   input  wire logic                          i_req_valid,
   output logic                               o_req_ready,
   input  wire logic                          i_req_write,
   input  wire logic [lpddr2_pkg::BANK_W-1:0] i_req_bank,
   input  wire logic [lpddr2_pkg::ROW_CAP_W-1:0] i_req_row,
   input  wire logic [lpddr2_pkg::COL_W-1:0]  i_req_col,
   output logic                               o_wr_take,
   input  wire logic [2*DW-1:0]               i_wr_data,
   input  wire logic [DW/4-1:0]               i_wr_mask,
   output logic                               o_rd_valid,
   output logic [2*DW-1:0]                    o_rd_data
);
   import lpddr2_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_ACT  = 3'b001,
      S_CMD  = 3'b010,
      S_DATA = 3'b011,
      S_PRE  = 3'b100
   } cst_t;

   cst_t                 state_q;
   logic                 wr_q;
   logic [BANK_W-1:0]    bank_q;
   logic [ROW_CAP_W-1:0] row_q;
   logic [COL_W-1:0]     col_q;
   logic [LAT_W-1:0]     lat_q;
   logic [PAIR_W-1:0]    pairs_q;
   logic [CYC_W-1:0]     cnt_q;
   logic [CYC_W-1:0]     win_lo;
   logic [CYC_W-1:0]     win_hi;
   logic [CYC_W-1:0]     cnt_nx;
   logic                 last;
   logic [CA_W-1:0]      ca_r_q;
   logic [CA_W-1:0]      ca_f_q;
   logic                 cs_n_q;
   logic                 cke_q;
   logic [2*DW-1:0]      dq_q;
   logic                 dq_oe_n_q;
   logic [DW/4-1:0]      dm_q;

   // Data window in cycles after the Read/Write command cycle
   assign win_lo = CYC_W'(lat_q);
   assign win_hi = CYC_W'(lat_q) + CYC_W'(pairs_q);
   assign cnt_nx = cnt_q + 6'h01;
   assign last   = (state_q == S_DATA) && (cnt_q == win_hi - 6'h01);
   assign o_req_ready = (state_q == S_IDLE);
   assign o_wr_take = wr_q && ((state_q == S_CMD) || (state_q == S_DATA)) &&
                      (cnt_nx >= win_lo) && (cnt_nx < win_hi);

   // Request sequencing: Activate first, then the access
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q <= S_IDLE;
         cnt_q   <= '0;
      end else begin
         case (state_q)
            S_IDLE: if (i_req_valid) state_q <= S_ACT;
            S_ACT:  begin
               state_q <= S_CMD;
               cnt_q   <= '0;
            end
            S_CMD:  begin
               state_q <= S_DATA;
               cnt_q   <= cnt_nx;
            end
            S_DATA: begin
               cnt_q <= cnt_nx;
               if (last) state_q <= S_PRE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // Request capture; latency and burst length frozen per access
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_q    <= 1'b0;
         bank_q  <= '0;
         row_q   <= '0;
         col_q   <= '0;
         lat_q   <= '0;
         pairs_q <= '0;
      end else if (o_req_ready && i_req_valid) begin
         wr_q    <= i_req_write;
         bank_q  <= i_req_bank;
         row_q   <= i_req_row;
         col_q   <= i_req_col;
         lat_q   <= i_req_write ? i_write_lat : i_read_lat;
         pairs_q <= bl_pairs(i_bl_code);
      end
   end

   // One command per cycle, both CA halves loaded together
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ca_r_q <= {7'h7F, NOP_PAT};
         ca_f_q <= '0;
         cs_n_q <= 1'b1;
         cke_q  <= 1'b0;
      end else begin
         cke_q  <= 1'b1;
         cs_n_q <= 1'b0;
         ca_f_q <= '0;
         ca_r_q <= {7'h7F, NOP_PAT};
         if (state_q == S_IDLE && i_req_valid) begin
            ca_r_q <= {i_req_bank, 1'b0, i_req_row[ROW_LO_W-1:0], ACT_PAT};
            ca_f_q <= i_req_row[ROW_LO_W +: CA_W];
         end else if (state_q == S_ACT) begin
            ca_r_q <= {bank_q, 4'h0, wr_q ? WR_PAT : RD_PAT};
            ca_f_q <= {1'b0, col_q};
         end else if (last) begin
            ca_r_q <= {bank_q, 3'h0, PRE_PAT};
         end
      end
   end

   // Write burst drive, one beat pair per cycle at the write latency
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         dq_q      <= '0;
         dm_q      <= '0;
         dq_oe_n_q <= 1'b1;
      end else begin
         dq_oe_n_q <= !o_wr_take;
         dm_q      <= o_wr_take ? i_wr_mask : '0;
         if (o_wr_take) dq_q <= i_wr_data;
      end
   end

   // Read burst capture at the read latency
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rd_valid <= 1'b0;
         o_rd_data  <= '0;
      end else begin
         o_rd_valid <= 1'b0;
         if (!wr_q && state_q == S_DATA && cnt_q >= win_lo &&
             cnt_q < win_hi) begin
            o_rd_valid <= 1'b1;
            o_rd_data  <= link.dq;
         end
      end
   end

   assign link.cs_n         = cs_n_q;
   assign link.cke          = cke_q;
   assign link.ca_r         = ca_r_q;
   assign link.ca_f         = ca_f_q;
   assign link.dm           = dm_q;
   assign link.dq_ctl_o     = dq_q;
   assign link.dq_ctl_oe_n  = dq_oe_n_q;
   // Strobe sent with write data, high in every cycle the data is driven, edge aligned
   assign link.dqs_ctl_o    = !dq_oe_n_q;
   assign link.dqs_ctl_oe_n = dq_oe_n_q;

endmodule : lpddr2_ctl_end

/* rtl/lpddr2_dev_end.sv */
// Purpose: Device end: decodes link commands, tracks open rows in eight
//          banks, serves read and write bursts from a storage array.
// Assumes: Read latency >= 2, write latency >= 1; one access at a time.
// Notes:   Storage keeps the low STORE_AW bits of the full word address.
// Notes on behaviour
// - CA bus is ten bits, carries everything.
// - Every command takes exactly one clock cycle.
// - CA carried on both halves of cycle.
// - Controller opens row with Activate before access.
// - Activate bank and row bits open that row.
// - Read/Write bits give bank and start column.
// - Eight independent banks, bank selected with addresses.
// - Bank, row, column span exactly one gigabit.
// - Burst length selectable as 4, 8, 16.
// - Read and write data follow programmed latencies.
// - Core fetches four words per internal access.
// - Data width is 16 or 32 bits.
// - Data mask blocks masked write bytes.
// - Chip select, clock enable sampled rising, command part.
// - Mask high with a beat masks that beat.
// - Device drives strobe on reads, receives on writes.
`timescale 1ns/1ps
module lpddr2_dev_end #(
   parameter int DW       = 32,
   parameter int STORE_AW = 12
) (
   input  wire logic                         i_clk,
   input  wire logic                         i_reset_n,
   lpddr2_link_if.dev                        link,
   input  wire logic [lpddr2_pkg::BLC_W-1:0] i_bl_code,
   input  wire logic [lpddr2_pkg::LAT_W-1:0] i_read_lat,
   input  wire logic [lpddr2_pkg::LAT_W-1:0] i_write_lat,
   output logic [lpddr2_pkg::NUM_BANKS-1:0]  o_bank_open,
   output logic                              o_busy,
   output logic                              o_cmd_reject
);
   import lpddr2_pkg::*;

   // Width variant and derived address split
   localparam int NB     = DW / 8;
   localparam int ROW_W  = row_width(DW);
   localparam int ADDR_W = BANK_W + ROW_W + COL_W;
   localparam int DEPTH  = 1 << STORE_AW;

   // Word address of beat k of a burst, wrapping inside the burst
   function automatic logic [STORE_AW-1:0] word_addr(
      input logic [BANK_W-1:0] b, input logic [ROW_W-1:0] r,
      input logic [COL_W-1:0] c, input logic [PAIR_W-1:0] pairs,
      input logic [PAIR_W-1:0] k);
      logic [COL_W-1:0]  m;
      logic [COL_W-1:0]  cw;
      logic [ADDR_W-1:0] full;
      m    = COL_W'({pairs, 1'b0}) - 9'h001;
      cw   = (c & ~m) | ((c + COL_W'(k)) & m);
      full = {b, r, cw};
      return full[STORE_AW-1:0];
   endfunction : word_addr

   logic [DW-1:0]        mem [DEPTH];
   logic [NUM_BANKS-1:0] open_q;
   logic [ROW_W-1:0]     row_q [NUM_BANKS];
   cmd_t                 cmd;
   logic [BANK_W-1:0]    bank_sel;
   logic [ROW_CAP_W-1:0] row_sel;
   logic                 accept;
   logic                 active_q;
   logic                 is_wr_q;
   logic [CYC_W-1:0]     cyc_q;
   logic [CYC_W-1:0]     cyc_nx;
   logic [CYC_W-1:0]     win_lo;
   logic [CYC_W-1:0]     win_hi;
   logic [BANK_W-1:0]    abank_q;
   logic [ROW_W-1:0]     arow_q;
   logic [COL_W-1:0]     acol_q;
   logic [LAT_W-1:0]     lat_q;
   logic [PAIR_W-1:0]    pairs_q;
   logic                 rd_load;
   logic                 wr_beat;
   logic [PAIR_W-1:0]    rd_pair;
   logic [PAIR_W-1:0]    wr_pair;
   logic [DW-1:0]        fetch [PREFETCH];
   logic [2*DW-1:0]      pf_q;
   logic [2*DW-1:0]      dq_q;
   logic                 dq_oe_n_q;
   logic                 dqs_q;
   logic                 reject_q;

   // Command decode; CS and CKE are part of the code
   assign cmd      = decode_cmd(link.cs_n, link.cke, link.ca_r);
   assign bank_sel = link.ca_r[BANK_LSB +: BANK_W];
   assign row_sel  = {link.ca_f, link.ca_r[ROW_LO_LSB +: ROW_LO_W]};
   assign accept   = ((cmd == CMD_RD) || (cmd == CMD_WR)) &&
                     open_q[bank_sel] && !active_q;

   // Bank table: Activate opens a row, Precharge closes it
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         open_q <= '0;
         for (int i = 0; i < NUM_BANKS; i++) begin
            row_q[i] <= '0;
         end
      end else if (cmd == CMD_ACT) begin
         open_q[bank_sel] <= 1'b1;
         row_q[bank_sel]  <= row_sel[ROW_W-1:0];
      end else if (cmd == CMD_PRE) begin
         open_q[bank_sel] <= 1'b0;
      end
   end

   // Reject pulse for access to a closed bank, overlap or bad code
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         reject_q <= 1'b0;
      end else begin
         reject_q <= (cmd == CMD_BAD) ||
                     (((cmd == CMD_RD) || (cmd == CMD_WR)) && !accept);
      end
   end

   // Access capture: bank, start column, latency, burst length
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         is_wr_q <= 1'b0;
         abank_q <= '0;
         arow_q  <= '0;
         acol_q  <= '0;
         lat_q   <= '0;
         pairs_q <= '0;
      end else if (accept) begin
         is_wr_q <= (cmd == CMD_WR);
         abank_q <= bank_sel;
         arow_q  <= row_q[bank_sel];
         acol_q  <= link.ca_f[COL_W-1:0];
         lat_q   <= (cmd == CMD_WR) ? i_write_lat : i_read_lat;
         pairs_q <= bl_pairs(i_bl_code);
      end
   end

   // Burst window in cycles after the command cycle
   assign cyc_nx = cyc_q + 6'h01;
   assign win_lo = CYC_W'(lat_q);
   assign win_hi = CYC_W'(lat_q) + CYC_W'(pairs_q);

   // Cycle counter of the access in flight
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         active_q <= 1'b0;
         cyc_q    <= '0;
      end else if (accept) begin
         active_q <= 1'b1;
         cyc_q    <= 6'h01;
      end else if (active_q) begin
         cyc_q <= cyc_nx;
         if (cyc_q >= win_hi - 6'h01) active_q <= 1'b0;
      end
   end

   // Read beats are registered one cycle ahead of the bus
   assign rd_load = active_q && !is_wr_q && (cyc_nx >= win_lo) &&
                    (cyc_nx < win_hi);
   assign rd_pair = PAIR_W'(cyc_nx - win_lo);
   assign wr_beat = active_q && is_wr_q && (cyc_q >= win_lo) &&
                    (cyc_q < win_hi) && link.dqs;
   assign wr_pair = PAIR_W'(cyc_q - win_lo);

   // Four-word core fetch for every second beat pair
   always_comb begin
      for (int i = 0; i < PREFETCH; i++) begin
         fetch[i] = mem[word_addr(abank_q, arow_q, acol_q, pairs_q,
                        PAIR_W'({rd_pair, 1'b0}) + PAIR_W'(i))];
      end
   end

   // Read data and strobe drive, edge aligned
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         dq_q      <= '0;
         pf_q      <= '0;
         dq_oe_n_q <= 1'b1;
         dqs_q     <= 1'b0;
      end else begin
         dq_oe_n_q <= !rd_load;
         dqs_q     <= rd_load;
         if (rd_load && !rd_pair[0]) begin
            dq_q <= {fetch[1], fetch[0]};
            pf_q <= {fetch[3], fetch[2]};
         end else if (rd_load) begin
            dq_q <= pf_q;
         end
      end
   end

   // Array write, per byte lane and per beat, honouring the mask
   always_ff @(posedge i_clk) begin
      if (wr_beat) begin
         for (int bt = 0; bt < 2; bt++) begin
            for (int ln = 0; ln < NB; ln++) begin
               if (!link.dm[bt*NB + ln]) begin
                  mem[word_addr(abank_q, arow_q, acol_q, pairs_q,
                      PAIR_W'({wr_pair, 1'b0}) + PAIR_W'(bt))][ln*8 +: 8]
                     <= link.dq[bt*DW + ln*8 +: 8];
               end
            end
         end
      end
   end

   assign link.dq_dev_o     = dq_q;
   assign link.dq_dev_oe_n  = dq_oe_n_q;
   assign link.dqs_dev_o    = dqs_q;
   assign link.dqs_dev_oe_n = dq_oe_n_q;
   assign o_bank_open       = open_q;
   assign o_busy            = active_q;
   assign o_cmd_reject      = reject_q;

endmodule : lpddr2_dev_end

/* rtl/lpddr2_link_if.sv */
// Purpose: Pin-level link between memory controller and LPDDR2 device.
// Assumes: dq/dqs resolved here from the active-low enables of both ends.
// Notes:   dq holds {fall beat, rise beat}; an undriven bus reads zero.
`timescale 1ns/1ps
interface lpddr2_link_if #(parameter int DW = 32);
   import lpddr2_pkg::*;
   localparam int NB = DW / 8;

   logic              cs_n;
   logic              cke;
   logic [CA_W-1:0]   ca_r;
   logic [CA_W-1:0]   ca_f;
   logic [2*NB-1:0]   dm;
   logic [2*DW-1:0]   dq_ctl_o;
   logic              dq_ctl_oe_n;
   logic [2*DW-1:0]   dq_dev_o;
   logic              dq_dev_oe_n;
   logic [2*DW-1:0]   dq;
   logic              dqs_ctl_o;
   logic              dqs_ctl_oe_n;
   logic              dqs_dev_o;
   logic              dqs_dev_oe_n;
   logic              dqs;

   // Wire level of the shared data and strobe pins
   assign dq  = !dq_dev_oe_n ? dq_dev_o : (!dq_ctl_oe_n ? dq_ctl_o : '0);
   assign dqs = !dqs_dev_oe_n ? dqs_dev_o : (!dqs_ctl_oe_n ? dqs_ctl_o : 1'b0);

   modport dev (input cs_n, cke, ca_r, ca_f, dm, dq, dqs,
                output dq_dev_o, dq_dev_oe_n, dqs_dev_o, dqs_dev_oe_n);
   modport ctl (input dq, dqs,
                output cs_n, cke, ca_r, ca_f, dm, dq_ctl_o, dq_ctl_oe_n,
                dqs_ctl_o, dqs_ctl_oe_n);
endinterface : lpddr2_link_if

/* rtl/lpddr2_pkg.sv */
// Purpose: Shared constants, command codes and helpers for the LPDDR2
//          command/access front end (controller end and device end).
// Assumes: One system clock; each memory clock cycle is one i_clk cycle,
//          rise and fall halves of the DDR buses carried side by side.
// Notes:   Command encodings follow the usual LPDDR2 CA0..CA3 patterns.
package lpddr2_pkg;

   // Bus and array geometry
   localparam int CA_W       = 10;
   localparam int NUM_BANKS  = 8;
   localparam int BANK_W     = 3;
   localparam int COL_W      = 9;
   localparam int ROW_W_X16  = 14;
   localparam int ROW_W_X32  = 13;
   localparam int ROW_CAP_W  = 14;
   localparam longint CAP_BITS = 64'd1073741824;
   localparam int PREFETCH   = 4;
   localparam int LAT_W      = 4;
   localparam int BLC_W      = 3;
   localparam int PAIR_W     = 5;
   localparam int CYC_W      = 6;

   // Field positions on the CA bus
   localparam int BANK_LSB   = 7;
   localparam int ROW_LO_LSB = 2;
   localparam int ROW_LO_W   = 4;

   // Burst length codes
   localparam logic [BLC_W-1:0] BL4_CODE  = 3'h2;
   localparam logic [BLC_W-1:0] BL8_CODE  = 3'h3;
   localparam logic [BLC_W-1:0] BL16_CODE = 3'h4;

   // Command patterns on the rising half of the CA bus
   localparam logic [1:0] ACT_PAT = 2'h2;
   localparam logic [2:0] WR_PAT  = 3'h1;
   localparam logic [2:0] RD_PAT  = 3'h5;
   localparam logic [3:0] PRE_PAT = 4'hB;
   localparam logic [2:0] NOP_PAT = 3'h7;

   typedef enum logic [2:0] {
      CMD_NOP = 3'b000,
      CMD_ACT = 3'b001,
      CMD_RD  = 3'b010,
      CMD_WR  = 3'b011,
      CMD_PRE = 3'b100,
      CMD_BAD = 3'b101
   } cmd_t;

   // Decode one command cycle; chip select and clock enable take part
   function automatic cmd_t decode_cmd(input logic cs_n, input logic cke,
                                       input logic [CA_W-1:0] ca);
      cmd_t c;
      c = CMD_BAD;
      if (cs_n || !cke) c = CMD_NOP;
      else if (ca[1:0] == ACT_PAT) c = CMD_ACT;
      else if (ca[2:0] == WR_PAT) c = CMD_WR;
      else if (ca[2:0] == RD_PAT) c = CMD_RD;
      else if (ca[3:0] == PRE_PAT) c = CMD_PRE;
      else if (ca[2:0] == NOP_PAT) c = CMD_NOP;
      return c;
   endfunction : decode_cmd

   // Clock cycles (beat pairs) per burst for a length code
   function automatic logic [PAIR_W-1:0] bl_pairs(input logic [BLC_W-1:0] c);
      logic [PAIR_W-1:0] p;
      p = 5'h04;
      if (c == BL4_CODE) p = 5'h02;
      else if (c == BL16_CODE) p = 5'h08;
      return p;
   endfunction : bl_pairs

   function automatic int row_width(input int dw);
      return (dw == 16) ? ROW_W_X16 : ROW_W_X32;
   endfunction : row_width

endpackage : lpddr2_pkg

/* tb/lpddr2_link_props.sv */
// Purpose: Timing and addressing checks on the link between both ends.
// Assumes: One clock domain; rise and fall CA halves seen side by side.
// Notes:   Latency checks index a short history of RD and WR commands.
`timescale 1ns/1ps
module lpddr2_link_props (
   input wire logic                                i_clk,
   input wire logic                                i_reset_n,
   input wire logic                                cs_n,
   input wire logic                                cke,
   input wire logic [lpddr2_pkg::CA_W-1:0]         ca_r,
   input wire logic                                dq_ctl_oe_n,
   input wire logic                                dq_dev_oe_n,
   input wire logic                                dqs,
   input wire logic [lpddr2_pkg::BLC_W-1:0]        i_bl_code,
   input wire logic [lpddr2_pkg::LAT_W-1:0]        i_read_lat,
   input wire logic [lpddr2_pkg::LAT_W-1:0]        i_write_lat,
   input wire logic [lpddr2_pkg::NUM_BANKS-1:0]    o_bank_open
);
   import lpddr2_pkg::*;
   logic        sel, act, pre, rw, rd_due, wr_due;
   logic [2:0]  bk;
   logic [15:0] rd_h, wr_h;
   logic [4:0]  run_q, pairs;

   // Command decode from the rising half, chip select and enable included
   assign sel = !cs_n && cke;
   assign act = sel && ca_r[1:0] == ACT_PAT;
   assign rw = sel && ca_r[1:0] == 2'h1;
   assign pre = sel && ca_r[3:0] == PRE_PAT;
   assign bk = ca_r[9:7];
   assign pairs = (i_bl_code == BL4_CODE) ? 5'h02 :
                  (i_bl_code == BL16_CODE) ? 5'h08 : 5'h04;
   assign rd_due = rd_h[i_read_lat - 4'h1];
   assign wr_due = wr_h[i_write_lat - 4'h1];

   // History of read and write commands, newest in bit 0
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rd_h <= '0;
         wr_h <= '0;
      end else begin
         rd_h <= {rd_h[14:0], rw && ca_r[2]};
         wr_h <= {wr_h[14:0], rw && !ca_r[2]};
      end
   end

   // Length of the current run of device-driven data cycles
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         run_q <= '0;
      end else begin
         run_q <= dq_dev_oe_n ? 5'h00 : run_q + 5'h01;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   sequence s_wr_pair;
      !dq_ctl_oe_n && dqs;
   endsequence
   sequence s_rd_pair;
      !dq_dev_oe_n && dq_ctl_oe_n && dqs;
   endsequence

   AST_RD_LAT: assert property (rd_due |-> s_rd_pair)
      else $error("read data missing at read latency");
   AST_WR_LAT: assert property (wr_due |-> s_wr_pair ##1 s_wr_pair)
      else $error("write data missing at write latency");
   AST_RD_BURST: assert property (
      $rose(dq_dev_oe_n) |-> run_q == pairs)
      else $error("read burst length wrong");
   AST_ACT_OPEN: assert property (act |=> o_bank_open[$past(bk)])
      else $error("activate did not open its bank");
   AST_PRE_CLOSE: assert property (pre |=> !o_bank_open[$past(bk)])
      else $error("precharge did not close its bank");
   AST_ACCESS_OPEN: assert property (rw |-> o_bank_open[bk])
      else $error("access to a bank with no open row");
   AST_ONE_CYCLE: assert property (act |=> !act)
      else $error("command held over two cycles");
   AST_ACT_TO_PRE: assert property (act |-> ##[2:60] pre)
      else $error("opened row never closed");
   AST_CKE_UP: assert property ($past(i_reset_n) |-> cke)
      else $error("clock enable low after reset");
endmodule : lpddr2_link_props

/* tb/test_lpddr2_command_access_front.sv */
// Purpose: Runs controller end against device end, checks data and wire.
// Assumes: x32 link; both ends share burst and latency settings.
// Notes:   Start columns are burst aligned, so reads return write order.
`timescale 1ns/1ps
module test_lpddr2_command_access_front;
   import lpddr2_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [2:0]  bl = 3'h2;
   logic [3:0]  rl = 4'h2;
   logic [3:0]  wl = 4'h1;
   logic        valid = 1'b0;
   logic        wr = 1'b0;
   logic        ready, take, rvalid, busy, rej;
   logic [2:0]  bank = 3'h0;
   logic [13:0] row = 14'h0000;
   logic [8:0]  col = 9'h000;
   logic [63:0] wdata = 64'h0;
   logic [7:0]  wmask = 8'h00;
   logic [63:0] rdata;
   logic [7:0]  bopen;
   logic [63:0] sh [0:7];
   logic [11:0] acc_w;
   logic [16:0] act_w;
   int          bad_count = 0;
   int          cmp_count = 0;
   int          rej_n = 0;

   always #4 clk = ~clk;

   lpddr2_link_if #(.DW(32)) lpddr2_link_if_i ();
   lpddr2_ctl_end #(.DW(32)) lpddr2_ctl_end_i (.i_clk(clk),
      .i_reset_n(rst_n), .link(lpddr2_link_if_i), .i_bl_code(bl),
      .i_read_lat(rl), .i_write_lat(wl), .i_req_valid(valid),
      .o_req_ready(ready), .i_req_write(wr), .i_req_bank(bank),
      .i_req_row(row), .i_req_col(col), .o_wr_take(take),
      .i_wr_data(wdata), .i_wr_mask(wmask), .o_rd_valid(rvalid),
      .o_rd_data(rdata));
   lpddr2_dev_end #(.DW(32), .STORE_AW(12)) lpddr2_dev_end_i (.i_clk(clk),
      .i_reset_n(rst_n), .link(lpddr2_link_if_i), .i_bl_code(bl),
      .i_read_lat(rl), .i_write_lat(wl), .o_bank_open(bopen),
      .o_busy(busy), .o_cmd_reject(rej));
   lpddr2_link_props lpddr2_link_props_i (.i_clk(clk), .i_reset_n(rst_n),
      .cs_n(lpddr2_link_if_i.cs_n), .cke(lpddr2_link_if_i.cke),
      .ca_r(lpddr2_link_if_i.ca_r), .dqs(lpddr2_link_if_i.dqs),
      .dq_ctl_oe_n(lpddr2_link_if_i.dq_ctl_oe_n),
      .dq_dev_oe_n(lpddr2_link_if_i.dq_dev_oe_n), .i_bl_code(bl),
      .i_read_lat(rl), .i_write_lat(wl), .o_bank_open(bopen));

   // Count device reject pulses; legal traffic must never raise one
   always @(negedge clk) begin
      if (rej) rej_n++;
   end

   // Capture bank, row and column as they cross the command bus
   always @(posedge clk) begin
      if (!lpddr2_link_if_i.cs_n && lpddr2_link_if_i.cke) begin
         if (lpddr2_link_if_i.ca_r[1:0] == ACT_PAT)
            act_w = {lpddr2_link_if_i.ca_r[9:7], lpddr2_link_if_i.ca_f,
                     lpddr2_link_if_i.ca_r[5:2]};
         if (lpddr2_link_if_i.ca_r[1:0] == 2'h1)
            acc_w = {lpddr2_link_if_i.ca_r[9:7], lpddr2_link_if_i.ca_f[8:0]};
      end
   end

   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   task automatic chk(input string what, input logic [63:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic tmo(input int n);
      if (n >= 200) begin
         bad_count++;
         $display("MISMATCH wait expected done seen hang");
         test_done;
      end
   endtask : tmo

   function automatic int npairs();
      return (bl == BL4_CODE) ? 2 : (bl == BL16_CODE) ? 8 : 4;
   endfunction : npairs

   // One user request; writes send a pattern, reads compare with shadow
   task automatic access(input logic w, input logic [2:0] b,
      input logic [13:0] r, input logic [8:0] c, input logic [31:0] base,
      input logic [7:0] m);
      int          n;
      int          k;
      logic [63:0] p;
      logic        seen_busy;
      @(negedge clk);
      valid = 1'b1;
      wr = w;
      bank = b;
      row = r;
      col = c;
      n = 0;
      // Ready is looked at where it is settled; the request is taken
      // at the rising edge that follows
      while (!ready && n < 200) begin
         @(negedge clk);
         n++;
      end
      tmo(n);
      @(posedge clk);
      k = 0;
      n = 0;
      seen_busy = 1'b0;
      while (k < npairs() && n < 200) begin
         @(negedge clk);
         valid = 1'b0;
         n++;
         seen_busy = seen_busy | busy;
         p = {base + 32'(2 * k + 1), base + 32'(2 * k)};
         if (w) begin
            wdata = p;
            wmask = m;
            if (take) begin
               for (int i = 0; i < 8; i++)
                  if (!m[i]) sh[k][8*i+:8] = p[8*i+:8];
               k++;
            end
         end else if (rvalid) begin
            chk("read pair", rdata, sh[k]);
            k++;
         end
      end
      tmo(n);
      chk("act row", {act_w[16:14], act_w[12:0]}, {b, r[12:0]});
      chk("access bank col", acc_w, {b, c});
      chk("busy seen", 64'(seen_busy), 64'h1);
      repeat (4) @(negedge clk);
      chk("banks open", bopen, 8'h00);
      chk("busy idle", 64'(busy), 64'h0);
      chk("rejects", 64'(rej_n), 64'h0);
   endtask : access

   // Main sequence: every burst length, then masked writes
   initial begin
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      for (int i = 0; i < 3; i++) begin
         bl = 3'h2 + 3'(i);
         rl = 4'h2 + 4'(3 * i);
         wl = 4'h1 + 4'(2 * i);
         access(1'b1, 3'(3 * i + 1), 14'h1FFD + 14'(i), 9'(i * 240),
                32'h5A00_0000 + 32'(i * 64), 8'h00);
         access(1'b0, 3'(3 * i + 1), 14'h1FFD + 14'(i), 9'(i * 240),
                32'h0, 8'h00);
         $display("test burst code %0d done", bl);
      end
      rl = 4'h3;
      wl = 4'h2;
      access(1'b1, 3'h2, 14'h0005, 9'h020, 32'h1111_2222, 8'h00);
      access(1'b1, 3'h2, 14'h0005, 9'h020, 32'h7777_8888, 8'h5A);
      access(1'b0, 3'h2, 14'h0005, 9'h020, 32'h0, 8'h00);
      $display("test mask done");
      test_done;
   end
endmodule : test_lpddr2_command_access_front
